// *** pc_stack_defines.vh ***
`ifndef PC_STACK_DEFINES_VH
`define PC_STACK_DEFINES_VH
// ==========================================
// Register offsets (byte addresses, one word each)
`define OFS_PC_LOW 8'h00
`define OFS_PC_HIGH_LATCH 8'h04
`define OFS_PC_UPPER_LATCH 8'h08
`define OFS_TOP_LOW 8'h0C
`define OFS_TOP_HIGH 8'h10
`define OFS_TOP_UPPER 8'h14
`define OFS_STACK_PTR 8'h18
`define OFS_SETUP 8'h1C
`define OFS_PC_FULL 8'h20
// ==========================================
// Field positions
`define BIT_FULL 7
`define BIT_UNDERFLOW 6
`define BIT_FAULT_RESET_EN 0
// ==========================================
// Vectors and reset values
`define VEC_RESET 21'h000000
`define VEC_HIGH 21'h000008
`define VEC_LOW 21'h000018
`define SETUP_RESET 1'b1
`define STACK_TOP 5'h1F
`define PC_STEP 21'h000002
`define CFG_WORDS_BYTES 21'h000008
`endif

// *** return_stack_ram.v ***
`timescale 1ns/100ps
// ==========================================
// Return stack storage, entries 1..DEPTH
module return_stack_ram #(
  parameter DEPTH = 31,
  parameter WIDTH = 21
) (
  // Clock
  input wire clock,
  input wire clock_en,
  // Write port
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read port
  input wire [4:0] rd_addr,
  output wire [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [1:DEPTH];
  // Index zero has no storage behind it
  assign rd_data = (rd_addr == 5'h00) ? {WIDTH{1'b0}} : mem[rd_addr];
  always @(posedge clock) begin
    if (clock_en && wr_en && wr_addr != 5'h00) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule

// *** program_counter_return_stack.v ***
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pc_stack_defines.vh"
// Function
// - 21-bit byte program counter, separate bus
// - Fetch above implemented memory returns zero
// - Any reset loads program counter 0000h
// - Interrupt vectors 0008h high, 0018h low
// - Top four words hold configuration data
// - Upper bytes written only through latches, read also via OFS_PC_FULL
// - Low byte write loads latches too
// - Low byte read copies upper bytes
// - Bit zero fixed, step of two
// - Calls and branches bypass the latches
// - 31 by 21 stack, 5-bit pointer
// - Push on calls, pop on returns
// - Push increments first; pop reads first
// - Calls and returns keep latches unchanged
// - Reset clears pointer; zero has no entry
// - Top registers access selected entry
// - Pointer software readable, writable, 0..31
// - Full flag after 31 pushes
// - Fault reset: store PC+2, flag, reset
// - No fault reset: pointer holds 31
// - Empty return loads zero; any empty pop sets underflow
// - Push stores PC; pop only decrements
// - Fault reset on underflow and overflow
// - Pointer register flag and field layout
module program_counter_return_stack #(
  parameter MEM_BYTES = 21'h020000,
  parameter DEPTH = 31
) (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  input wire clock_en,
  input wire por_event,
  // Core operations
  input wire op_advance,
  input wire op_call,
  input wire op_push,
  input wire op_pop_return,
  input wire op_pop_discard,
  input wire op_jump,
  input wire [20:0] jump_target,
  input wire op_irq_high,
  input wire op_irq_low,
  input wire op_ext_unlink,
  input wire ext_set_enable,
  // Program memory fetch
  input wire [15:0] mem_rdata,
  output reg [20:0] fetch_addr,
  output reg [15:0] fetch_word,
  output reg cfg_region,
  // Device reset request
  output reg fault_reset,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest
);
  // Lowest byte of the configuration words at the top of memory
  localparam [20:0] CFG_BASE = MEM_BYTES - `CFG_WORDS_BYTES;
  reg [20:0] pc;
  reg [7:0] pc_high_latch;
  reg [4:0] pc_upper_latch;
  reg [4:0] stack_ptr;
  reg stack_full_flag;
  reg stack_underflow_flag;
  reg stack_fault_reset_enable;
  reg fault_pending;
  reg [20:0] next_pc;
  reg [4:0] next_ptr;
  reg next_full;
  reg next_unf;
  reg wr_en;
  reg [20:0] wr_data;
  reg fault;
  reg [7:0] top_byte;
  reg [20:0] tos_wdata;
  reg tos_wr;
  reg ram_wr;
  reg [4:0] ram_addr;
  reg [20:0] ram_data;
  wire [20:0] top_entry;
  wire bus_req;
  wire wr_stb;
  wire rd_stb;
  wire do_push;
  wire do_pop;
  wire pop_unlink;
  wire [20:0] pc_seq;

  // ==========================================
  // Bus decode: single wait state, acknowledged on second cycle
  assign bus_req = avs_read | avs_write;
  assign wr_stb = avs_write & ~avs_waitrequest;
  assign rd_stb = avs_read & ~avs_waitrequest;
  // Limitation: clock_en must stay high through a transfer, or an
  // acknowledged access is lost while state is frozen

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if (clock_en) begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  // ==========================================
  // Stack storage
  return_stack_ram #(.DEPTH(DEPTH), .WIDTH(21)) u_ram (
    .clock(clock),
    .clock_en(clock_en),
    .wr_en(ram_wr),
    .wr_addr(ram_addr),
    .wr_data(ram_data),
    .rd_addr(stack_ptr),
    .rd_data(top_entry)
  );

  assign pc_seq = pc + `PC_STEP;
  assign pop_unlink = op_ext_unlink & ext_set_enable;
  assign do_push = op_call | op_push | op_irq_high | op_irq_low;
  assign do_pop = op_pop_return | pop_unlink | op_pop_discard;

  // ==========================================
  // Next-state logic
  always @* begin
    next_pc = pc;
    next_ptr = stack_ptr;
    next_full = stack_full_flag;
    next_unf = stack_underflow_flag;
    wr_en = 1'b0;
    wr_data = pc_seq;
    fault = 1'b0;
    if (op_advance) begin
      next_pc = pc_seq;
    end
    if (do_push) begin
      // Calls save the following instruction; push saves the current PC
      wr_data = op_push ? pc : pc_seq;
      // Once full, entry 31 and the pointer stay put
      if (stack_ptr == `STACK_TOP) begin
        next_full = 1'b1;
        fault = stack_fault_reset_enable;
      end else begin
        next_ptr = stack_ptr + 5'h01;
        wr_en = 1'b1;
        if (next_ptr == DEPTH[4:0]) begin
          next_full = 1'b1;
          fault = stack_fault_reset_enable;
        end
      end
      if (op_call) begin
        next_pc = {jump_target[20:1], 1'b0};
      end
      if (op_irq_high) begin
        next_pc = `VEC_HIGH;
      end else if (op_irq_low) begin
        next_pc = `VEC_LOW;
      end
    end else if (do_pop) begin
      // Empty pop sets underflow and, unless discarding, vectors to zero; the pointer holds
      if (stack_ptr == 5'h00) begin
        next_unf = 1'b1;
        fault = stack_fault_reset_enable;
        if (!op_pop_discard) begin
          next_pc = `VEC_RESET;
        end
      end else begin
        if (!op_pop_discard) begin
          next_pc = top_entry;
        end
        next_ptr = stack_ptr - 5'h01;
      end
    end else if (op_jump) begin
      next_pc = {jump_target[20:1], 1'b0};
    end
    next_pc[0] = 1'b0;
  end

  // ==========================================
  // Main state
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pc <= `VEC_RESET;
      pc_high_latch <= 8'h00;
      pc_upper_latch <= 5'h00;
      stack_ptr <= 5'h00;
      stack_full_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
      stack_fault_reset_enable <= `SETUP_RESET;
      fault_pending <= 1'b0;
      fault_reset <= 1'b0;
    end else if (clock_en) begin
      fault_reset <= fault_pending;
      if (fault_pending) begin
        // Stack fault reset: flags survive, only a power-on clears them
        fault_pending <= 1'b0;
        pc <= `VEC_RESET;
        stack_ptr <= 5'h00;
        if (por_event) begin
          stack_full_flag <= 1'b0;
          stack_underflow_flag <= 1'b0;
        end
      end else if (por_event) begin
        // Power-on clears the sticky flags; a stack fault reset leaves them
        pc <= `VEC_RESET;
        stack_ptr <= 5'h00;
        stack_full_flag <= 1'b0;
        stack_underflow_flag <= 1'b0;
        pc_high_latch <= 8'h00;
        pc_upper_latch <= 5'h00;
      end else begin
        // Core ops first; software writes override pointer or PC
        pc <= next_pc;
        stack_ptr <= next_ptr;
        fault_pending <= fault;
        stack_full_flag <= next_full;
        stack_underflow_flag <= next_unf;
        // Latches move only on low-byte reads, their own writes and power-on, never on calls or returns
        if (rd_stb && avs_address == `OFS_PC_LOW) begin
          pc_high_latch <= pc[15:8];
          pc_upper_latch <= pc[20:16];
        end
        if (wr_stb) begin
          case (avs_address)
            `OFS_PC_LOW: begin
              pc <= {pc_upper_latch, pc_high_latch, avs_writedata[7:1], 1'b0};
            end
            `OFS_PC_HIGH_LATCH: begin
              pc_high_latch <= avs_writedata[7:0];
            end
            `OFS_PC_UPPER_LATCH: begin
              pc_upper_latch <= avs_writedata[4:0];
            end
            `OFS_STACK_PTR: begin
              stack_ptr <= avs_writedata[4:0];
              // Writing zero clears a flag, writing one leaves it alone
              // Hardware set wins over clear
              stack_full_flag <= next_full & (avs_writedata[`BIT_FULL] |
                (next_full & ~stack_full_flag));
              stack_underflow_flag <= next_unf & (avs_writedata[`BIT_UNDERFLOW] |
                (next_unf & ~stack_underflow_flag));
            end
            `OFS_SETUP: begin
              stack_fault_reset_enable <= avs_writedata[`BIT_FAULT_RESET_EN];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ==========================================
  // Top-of-stack software writes, dropped at pointer zero (no slot)
  always @* begin
    tos_wdata = top_entry;
    tos_wr = 1'b0;
    if (wr_stb && stack_ptr != 5'h00) begin
      case (avs_address)
        `OFS_TOP_LOW: begin
          tos_wdata[7:0] = avs_writedata[7:0];
          tos_wr = 1'b1;
        end
        `OFS_TOP_HIGH: begin
          tos_wdata[15:8] = avs_writedata[7:0];
          tos_wr = 1'b1;
        end
        `OFS_TOP_UPPER: begin
          tos_wdata[20:16] = avs_writedata[4:0];
          tos_wr = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // Stack write port arbitration
  // A core push outranks a software write; reset cycles drop the
  // core request, so storage must hold as well
  always @* begin
    ram_wr = 1'b0;
    ram_addr = stack_ptr;
    ram_data = tos_wdata;
    if (fault_pending || por_event) begin
      ram_wr = 1'b0;
    end else if (wr_en) begin
      ram_wr = 1'b1;
      ram_addr = next_ptr;
      ram_data = wr_data;
    end else if (tos_wr) begin
      ram_wr = 1'b1;
    end
  end


  // ==========================================
  // Read mux
  always @* begin
    case (avs_address)
      `OFS_PC_LOW: top_byte = pc[7:0];
      `OFS_PC_HIGH_LATCH: top_byte = pc_high_latch;
      `OFS_PC_UPPER_LATCH: top_byte = {3'h0, pc_upper_latch};
      `OFS_TOP_LOW: top_byte = top_entry[7:0];
      `OFS_TOP_HIGH: top_byte = top_entry[15:8];
      `OFS_TOP_UPPER: top_byte = {3'h0, top_entry[20:16]};
      `OFS_STACK_PTR: top_byte = {stack_full_flag, stack_underflow_flag, 1'b0, stack_ptr};
      `OFS_SETUP: top_byte = {7'h00, stack_fault_reset_enable};
      default: top_byte = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
      fetch_addr <= 21'h000000;
      fetch_word <= 16'h0000;
      cfg_region <= 1'b0;
    end else if (clock_en) begin
      // Taken on the request edge, so it stands at the acknowledge edge
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= (avs_address == `OFS_PC_FULL) ? {11'h000, pc} : {24'h000000, top_byte};
      end
      fetch_addr <= pc;
      // Unimplemented space reads as zero, a no-op for the core
      fetch_word <= (pc < MEM_BYTES) ? mem_rdata : 16'h0000;
      cfg_region <= (pc >= CFG_BASE) && (pc < MEM_BYTES);
    end
  end
endmodule

// *** pc_stack_asserts.sv ***
`timescale 1ns/100ps
// ==========================================
// Port checks
module pc_stack_asserts #(
  parameter MEM_BYTES = 21'h020000
) (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  input wire por_event,
  // Operations
  input wire op_jump,
  input wire [20:0] jump_target,
  input wire op_irq_high,
  input wire op_irq_low,
  // Fetch
  input wire [20:0] fetch_addr,
  input wire [15:0] fetch_word,
  input wire cfg_region,
  input wire fault_reset,
  // Bus
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_PC_EVEN:
    assert property (fetch_addr[0] == 1'b0) else $error("odd program counter");
  AST_RESET_VECTOR:
    assert property ($rose(rst_b) |-> fetch_addr == 21'h000000) else $error("reset vector");
  AST_POR_VECTOR:
    assert property (por_event |-> ##[1:2] fetch_addr == 21'h000000) else $error("por vector");
  AST_IRQ_HIGH:
    assert property (op_irq_high |-> ##[1:2] fetch_addr == 21'h000008) else $error("high vector");
  AST_IRQ_LOW:
    assert property (op_irq_low |-> ##[1:2] fetch_addr == 21'h000018) else $error("low vector");
  AST_JUMP:
    assert property (op_jump |-> ##[1:2] fetch_addr == jump_target) else $error("jump target");
  AST_ABOVE_MEM:
    assert property (fetch_addr >= MEM_BYTES && $stable(fetch_addr)
      && fetch_addr == $past(fetch_addr, 2) |-> fetch_word == 16'h0000) else $error("fetch word");
  AST_CFG_REGION:
    assert property ($stable(fetch_addr) |-> cfg_region ==
      (fetch_addr >= MEM_BYTES - 8 && fetch_addr < MEM_BYTES)) else $error("setup region");
  AST_BUS_ANSWER:
    assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
      else $error("bus answer late");
  AST_BUS_ONE_CYCLE:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("bus answer long");
  AST_FAULT_PULSE:
    assert property (fault_reset |=> !fault_reset) else $error("fault pulse long");
endmodule
bind program_counter_return_stack pc_stack_asserts #(.MEM_BYTES(MEM_BYTES)) u_pc_stack_asserts (.*);

// *** core_decoder_model.sv ***
`timescale 1ns/100ps
// ==========================================
// Decoder and program memory model
module core_decoder_model (
  // One operation code a cycle
  input wire [3:0] cmd,
  // Operation pulses
  output wire op_advance,
  output wire op_call,
  output wire op_push,
  output wire op_pop_return,
  output wire op_pop_discard,
  output wire op_jump,
  output wire op_irq_high,
  output wire op_irq_low,
  output wire op_ext_unlink,
  // Program memory
  input wire [20:0] fetch_addr,
  output wire [15:0] mem_rdata
);
  // Decoding one code keeps the pulses one-hot
  assign op_advance = cmd == 4'h1;
  assign op_call = cmd == 4'h2;
  assign op_push = cmd == 4'h3;
  assign op_pop_return = cmd == 4'h4;
  assign op_pop_discard = cmd == 4'h5;
  assign op_jump = cmd == 4'h6;
  assign op_irq_high = cmd == 4'h7;
  assign op_irq_low = cmd == 4'h8;
  assign op_ext_unlink = cmd == 4'h9;
  // Address-dependent word, so a zero fill stands out
  assign mem_rdata = fetch_addr[16:1] ^ 16'hA5C3;
endmodule

// *** program_counter_return_stack_test.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module program_counter_return_stack_test;
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  reg por_event = 1'b0;
  reg ext_set_enable = 1'b0;
  reg [3:0] cmd = 4'h0;
  reg [20:0] jump_target = 21'h000000;
  reg [7:0] avs_address = 8'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  reg [31:0] seed = 32'h00007E97;
  reg [31:0] e_now;
  reg [31:0] expq[$];
  reg [20:0] t;
  integer n_fail = 0, compares = 0, cycles = 0, n_fault = 0, i;
  wire op_advance, op_call, op_push, op_pop_return, op_pop_discard, op_jump;
  wire op_irq_high, op_irq_low, op_ext_unlink, cfg_region, fault_reset, avs_waitrequest;
  wire [15:0] mem_rdata, fetch_word;
  wire [20:0] fetch_addr;
  wire [31:0] avs_readdata;
  program_counter_return_stack u_program_counter_return_stack (.clock(clock), .rst_b(rst_b),
    .clock_en(1'b1), .por_event(por_event), .op_advance(op_advance), .op_call(op_call),
    .op_push(op_push), .op_pop_return(op_pop_return), .op_pop_discard(op_pop_discard),
    .op_jump(op_jump), .jump_target(jump_target), .op_irq_high(op_irq_high),
    .op_irq_low(op_irq_low), .op_ext_unlink(op_ext_unlink), .ext_set_enable(ext_set_enable),
    .mem_rdata(mem_rdata), .fetch_addr(fetch_addr), .fetch_word(fetch_word),
    .cfg_region(cfg_region), .fault_reset(fault_reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  core_decoder_model u_core_decoder_model (.cmd(cmd), .op_advance(op_advance),
    .op_call(op_call), .op_push(op_push), .op_pop_return(op_pop_return),
    .op_pop_discard(op_pop_discard), .op_jump(op_jump), .op_irq_high(op_irq_high),
    .op_irq_low(op_irq_low), .op_ext_unlink(op_ext_unlink), .fetch_addr(fetch_addr),
    .mem_rdata(mem_rdata));
  always #5 clock = ~clock;
  function [31:0] xorshift(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
    end
  endfunction
  task wrap_up;
    begin
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Request held until waitrequest is sampled low
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clock);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      expq.push_back(e);
      bus(1'b0, a, 32'h00000000);
    end
  endtask
  task op(input [3:0] k, input [20:0] tg);
    begin
      @(posedge clock);
      cmd <= k;
      jump_target <= tg;
      @(posedge clock);
      cmd <= 4'h0;
      repeat (3) @(posedge clock);
    end
  endtask
  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      e_now = expq.pop_front();
      `CHK(avs_readdata, e_now)
    end
    if (fault_reset === 1'b1) n_fault = n_fault + 1;
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h1);
    rd(8'h40, 32'h0);
    for (i = 0; i < 3; i = i + 1) op(4'h1, 21'h0);
    rd(8'h20, 32'h6);
    bus(1'b1, 8'h04, 32'h12);
    bus(1'b1, 8'h08, 32'h01);
    bus(1'b1, 8'h00, 32'h41);
    rd(8'h20, 32'h011240);
    seed = xorshift(seed);
    t = {4'h0, seed[16:1], 1'b0};
    op(4'h6, t);
    rd(8'h20, t);
    rd(8'h00, t[7:0]);
    rd(8'h04, t[15:8]);
    rd(8'h08, t[20:16]);
    op(4'h2, 21'h001000);
    rd(8'h18, 32'h1);
    rd(8'h04, t[15:8]);
    seed = xorshift(seed);
    t = {seed[20:1], 1'b0};
    bus(1'b1, 8'h0C, t[7:0]);
    bus(1'b1, 8'h10, t[15:8]);
    bus(1'b1, 8'h14, t[20:16]);
    rd(8'h10, t[15:8]);
    op(4'h4, 21'h0);
    rd(8'h20, t);
    bus(1'b1, 8'h1C, 32'h0);
    op(4'h4, 21'h0);
    rd(8'h20, 32'h0);
    rd(8'h18, 32'h40);
    bus(1'b1, 8'h18, 32'h0);
    op(4'h7, 21'h0);
    op(4'h8, 21'h0);
    rd(8'h18, 32'h2);
    op(4'h9, 21'h0);
    rd(8'h18, 32'h2);
    ext_set_enable <= 1'b1;
    op(4'h9, 21'h0);
    rd(8'h18, 32'h1);
    op(4'h5, 21'h0);
    rd(8'h18, 32'h0);
    op(4'h3, 21'h0);
    rd(8'h18, 32'h1);
    bus(1'b1, 8'h18, 32'h1E);
    op(4'h3, 21'h0);
    rd(8'h18, 32'h9F);
    op(4'h3, 21'h0);
    rd(8'h18, 32'h9F);
    bus(1'b1, 8'h1C, 32'h1);
    bus(1'b1, 8'h18, 32'h1E);
    op(4'h3, 21'h0);
    rd(8'h18, 32'h80);
    `CHK(n_fault, 1)
    op(4'h4, 21'h0);
    rd(8'h18, 32'hC0);
    `CHK(n_fault, 2)
    @(posedge clock);
    por_event <= 1'b1;
    @(posedge clock);
    por_event <= 1'b0;
    rd(8'h18, 32'h0);
    op(4'h6, 21'h01FFFA);
    `CHK(cfg_region, 1'b1)
    `CHK(fetch_word, 16'h5A3E)
    op(4'h6, 21'h020010);
    `CHK(cfg_region, 1'b0)
    `CHK(fetch_word, 16'h0000)
    wrap_up;
  end
endmodule
